// *** src/wdrt_regs.svh ***
// Register offsets, field positions, reset values and divider limits of the watchdog
`ifndef WDRT_REGS_SVH
`define WDRT_REGS_SVH

`define WDRT_ADDR_W 12
`define WDRT_OFF_CLK 12'h000
`define WDRT_OFF_CTL 12'h004
`define WDRT_OFF_KEY 12'h008
`define WDRT_OFF_STAT 12'h00C

`define WDRT_CLK_SRC_LSB 0
`define WDRT_CLK_DIV_LSB 4
`define WDRT_CLK_DEBUG_RUN_BIT 8
`define WDRT_CTL_RUN_LSB 0
`define WDRT_CTL_CLR_BIT 4
`define WDRT_STAT_RUN_BIT 16
`define WDRT_STAT_REQ_BIT 17
`define WDRT_STAT_UNLK_BIT 18

`define WDRT_KEY_UNLOCK 16'h0096
`define WDRT_KEY_RESET 16'h0000
`define WDRT_RUN_STOP 4'hA
`define WDRT_RUN_GOING 4'h0
`define WDRT_COUNT_MAX 10'h3FF

`define WDRT_SRC_IOSC 2'h0
`define WDRT_SRC_LOSC 2'h1
`define WDRT_SRC_HOSC 2'h2
`define WDRT_SRC_EXT 2'h3
`define WDRT_LIM_8K 16'h1FFF
`define WDRT_LIM_16K 16'h3FFF
`define WDRT_LIM_32K 16'h7FFF
`define WDRT_LIM_64K 16'hFFFF
`define WDRT_LIM_LOSC 16'h007F
`define WDRT_LIM_EXT 16'h0000

`endif

// *** src/wdrt_pkg.sv ***
// Types shared by the watchdog modules
package wdrt_pkg;

    typedef enum logic [1:0] {
        WDRT_BUS_IDLE = 2'b01,
        WDRT_BUS_ANSWER = 2'b10
    } wdrt_bus_st_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wdrt_apb_req_t;

    typedef struct packed {
        wdrt_bus_st_t bus_st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic debug_run;
        logic [1:0] clk_div;
        logic [1:0] clk_src;
        logic running;
        logic [15:0] key;
        logic [9:0] count;
        logic reset_req;
    } wdrt_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } wdrt_div_state_t;

endpackage : wdrt_pkg

// *** src/wdrt_sync_edge.sv ***
// Two-flop synchronisers with rising edge detection for the clock source inputs
`timescale 1ns/100ps
`default_nettype none
module wdrt_sync_edge #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] rise
);
    import wdrt_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] rise;
    } wdrt_sync_state_t;

    wdrt_sync_state_t st_q;
    wdrt_sync_state_t st_d;

    // Edge taken between second and third stage only
    always_comb begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.rise = st_q.s2 & ~st_q.s3;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise = st_q.rise;

endmodule : wdrt_sync_edge
`default_nettype wire

// *** src/wdrt_divider.sv ***
// Selectable prescaler producing the watchdog counter clock tick
`timescale 1ns/100ps
`default_nettype none
`include "wdrt_regs.svh"
module wdrt_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_tick,
    input wire logic hold,
    input wire logic clear,
    input wire logic [1:0] clk_src,
    input wire logic [1:0] clk_div,
    output logic tick
);
    import wdrt_pkg::*;

    wdrt_div_state_t st_q;
    wdrt_div_state_t st_d;
    logic [15:0] limit;

    // Terminal count for source and ratio
    function automatic logic [15:0] div_limit(input logic [1:0] src, input logic [1:0] div);
        logic [15:0] lim;
        lim = `WDRT_LIM_EXT;
        if (src == `WDRT_SRC_LOSC) begin
            lim = `WDRT_LIM_LOSC;
        end else if (src == `WDRT_SRC_EXT) begin
            lim = `WDRT_LIM_EXT;
        end else if (div == 2'h0) begin
            lim = `WDRT_LIM_8K;
        end else if (div == 2'h1) begin
            lim = `WDRT_LIM_16K;
        end else if (div == 2'h2) begin
            lim = `WDRT_LIM_32K;
        end else begin
            lim = `WDRT_LIM_64K;
        end
        return lim;
    endfunction : div_limit

    assign limit = div_limit(clk_src, clk_div);

    // divide the selected source; >= copes with a lowered ratio
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (clear) begin
            st_d.cnt = 16'h0000;
        end else if (src_tick && !hold) begin
            if (st_q.cnt >= limit) begin
                st_d.cnt = 16'h0000;
                st_d.tick = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ext_every_edge: assert property ((src_tick && !hold && !clear && clk_src == 2'h3) |=> tick)
        else $error("external source edge gave no tick");
    a_hold_no_tick: assert property ((hold || clear) |=> !tick)
        else $error("tick while divider held");

endmodule : wdrt_divider
`default_nettype wire

// *** src/wdrt_top.sv ***
// Watchdog reset timer: APB registers, protection key, 10-bit counter and reset request
//
// How it works
// - A 10-bit up counter counts divided counter clock ticks while running.
// - Counter overflow raises the system reset request.
// - Overflow comes 1,024 counter ticks after a clear or reset.
// - Counter clock is the selected source divided by the selected ratio.
// - Debug mode without debug run freezes the counter clock and counting.
// - Debug mode with debug run keeps the counter clock and counting.
// - Writing 1 to the clear bit resets the counter to zero.
// - Run field value 0xa stops the watchdog, any other value starts it.
// - Run field resets stopped, reads 0xa stopped and 0x0 running.
// - Clear bit always reads back as zero.
// - Ratios 1/8,192 to 1/65,536, 1/128 slow source, 1/1 external.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "wdrt_regs.svh"
module wdrt_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire wdrt_pkg::wdrt_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] osc_clk_in,
    input wire logic cpu_debug,
    output logic sys_reset_req
);
    import wdrt_pkg::*;

    localparam int HIT_CLK = 0;
    localparam int HIT_CTL = 1;
    localparam int HIT_KEY = 2;
    localparam int HIT_STAT = 3;

    wdrt_state_t st_q;
    wdrt_state_t st_d;
    logic [3:0] src_edge;
    logic src_tick;
    logic div_tick;
    logic clk_hold;
    logic unlocked;
    logic [3:0] hit;
    logic commit;
    logic wr_commit;
    logic rd_arm;
    logic counter_clear;
    logic count_step;
    logic overflow;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic [3:0] reg_hit(input logic [11:0] addr);
        logic [3:0] h;
        h = 4'h0;
        if (addr == `WDRT_OFF_CLK) begin
            h = 4'h1;
        end else if (addr == `WDRT_OFF_CTL) begin
            h = 4'h2;
        end else if (addr == `WDRT_OFF_KEY) begin
            h = 4'h4;
        end else if (addr == `WDRT_OFF_STAT) begin
            h = 4'h8;
        end
        return h;
    endfunction : reg_hit

    assign hit = reg_hit(apb_req.paddr);
    // Writes land only on the edge where pready is seen high, reads sample on the edge before
    assign commit = apb_req.psel && apb_req.penable && st_q.pready;
    assign wr_commit = commit && apb_req.pwrite;
    assign rd_arm = apb_req.psel && apb_req.penable && !st_q.pready && !apb_req.pwrite;

    // unlocked only while the key holds the unlock value
    assign unlocked = (st_q.key == `WDRT_KEY_UNLOCK);

    ////////////////////////////////////////////////////////////////////////////////
    // Counter clock path

    wdrt_sync_edge #(
        .WIDTH(4)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(osc_clk_in),
        .rise(src_edge)
    );

    // pick the source chosen by the select field
    assign src_tick = src_edge[st_q.clk_src];

    // clock gated in debug unless debug run is set
    // debug run keeps the clock flowing
    assign clk_hold = !st_q.running || (cpu_debug && !st_q.debug_run);

    // clear only when unlocked and bit written as 1
    assign counter_clear = wr_commit && hit[HIT_CTL] && unlocked && apb_req.pwdata[`WDRT_CTL_CLR_BIT];

    wdrt_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick),
        .hold(clk_hold),
        .clear(counter_clear),
        .clk_src(st_q.clk_src),
        .clk_div(st_q.clk_div),
        .tick(div_tick)
    );

    assign count_step = div_tick && !clk_hold;
    // full period ends on the tick at 0x3FF
    assign overflow = count_step && (st_q.count == `WDRT_COUNT_MAX);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [31:0] rdata;
        rdata = 32'h0000_0000;
        st_d = st_q;

        if (hit[HIT_CLK]) begin
            rdata[`WDRT_CLK_DEBUG_RUN_BIT] = st_q.debug_run;
            rdata[`WDRT_CLK_DIV_LSB +: 2] = st_q.clk_div;
            rdata[`WDRT_CLK_SRC_LSB +: 2] = st_q.clk_src;
        end else if (hit[HIT_CTL]) begin
            // run field reads idle or running code
            rdata[`WDRT_CTL_RUN_LSB +: 4] = st_q.running ? `WDRT_RUN_GOING : `WDRT_RUN_STOP;
        end else if (hit[HIT_KEY]) begin
            rdata[15:0] = st_q.key;
        end else if (hit[HIT_STAT]) begin
            rdata[9:0] = st_q.count;
            rdata[`WDRT_STAT_RUN_BIT] = st_q.running;
            rdata[`WDRT_STAT_REQ_BIT] = st_q.reset_req;
            rdata[`WDRT_STAT_UNLK_BIT] = unlocked;
        end

        case (st_q.bus_st)
            WDRT_BUS_IDLE: begin
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
                if (apb_req.psel && apb_req.penable) begin
                    st_d.bus_st = WDRT_BUS_ANSWER;
                    st_d.pready = 1'b1;
                    st_d.pslverr = (hit == 4'h0);
                    st_d.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
                end
            end
            WDRT_BUS_ANSWER: begin
                st_d.bus_st = WDRT_BUS_IDLE;
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
                st_d.prdata = 32'h0000_0000;
            end
            default: begin
                st_d.bus_st = WDRT_BUS_IDLE;
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
            end
        endcase

        // protected clock bits need the key
        if (wr_commit && hit[HIT_CLK] && unlocked) begin
            st_d.debug_run = apb_req.pwdata[`WDRT_CLK_DEBUG_RUN_BIT];
            st_d.clk_div = apb_req.pwdata[`WDRT_CLK_DIV_LSB +: 2];
            st_d.clk_src = apb_req.pwdata[`WDRT_CLK_SRC_LSB +: 2];
        end

        // stop code halts, anything else runs
        if (wr_commit && hit[HIT_CTL] && unlocked) begin
            st_d.running = (apb_req.pwdata[`WDRT_CTL_RUN_LSB +: 4] != `WDRT_RUN_STOP);
        end

        if (wr_commit && hit[HIT_KEY]) begin
            st_d.key = apb_req.pwdata[15:0];
        end

        // clear beats a tick in the same cycle
        // step on each counter clock tick, wrapping at overflow
        if (counter_clear) begin
            st_d.count = 10'h000;
        end else if (count_step) begin
            st_d.count = st_q.count + 10'h001;
        end

        // overflow sets the request, set wins over clear
        if (counter_clear) begin
            st_d.reset_req = 1'b0;
        end
        if (overflow) begin
            st_d.reset_req = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.bus_st <= WDRT_BUS_IDLE;
            st_q.pready <= 1'b0;
            st_q.pslverr <= 1'b0;
            st_q.prdata <= 32'h0000_0000;
            st_q.debug_run <= 1'b0;
            st_q.clk_div <= 2'h0;
            st_q.clk_src <= 2'h0;
            st_q.running <= 1'b0;
            st_q.key <= `WDRT_KEY_RESET;
            st_q.count <= 10'h000;
            st_q.reset_req <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign sys_reset_req = st_q.reset_req;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_count_step: assert property ((count_step && !counter_clear && st_q.count != 10'h3FF)
        |=> st_q.count == $past(st_q.count) + 10'h001)
        else $error("counter did not step on tick");

    a_count_no_tick: assert property ((!div_tick && !counter_clear) |=> $stable(st_q.count))
        else $error("counter moved without a tick");

    a_stat_count: assert property ((rd_arm && hit[HIT_STAT]) |=> prdata[9:0] == $past(st_q.count))
        else $error("status read gave wrong count");

    a_overflow_req: assert property (overflow |=> sys_reset_req && st_q.count == 10'h000)
        else $error("overflow did not raise reset request");

    a_req_sticky: assert property ((sys_reset_req && !counter_clear) |=> sys_reset_req)
        else $error("reset request dropped without clear");

    a_req_cause: assert property ((!sys_reset_req && !overflow) |=> !sys_reset_req)
        else $error("reset request rose without overflow");

    a_req_at_full: assert property ($rose(sys_reset_req) |-> $past(st_q.count) == 10'h3FF)
        else $error("reset request before full period");

    a_clk_write: assert property ((wr_commit && hit[HIT_CLK] && unlocked)
        |=> {st_q.debug_run, st_q.clk_div, st_q.clk_src}
            == {$past(apb_req.pwdata[8]), $past(apb_req.pwdata[5:4]), $past(apb_req.pwdata[1:0])})
        else $error("clock control write not applied");

    a_key_write: assert property ((wr_commit && hit[HIT_KEY]) |=> st_q.key == $past(apb_req.pwdata[15:0]))
        else $error("key write not applied");

    a_key_readback: assert property ((rd_arm && hit[HIT_KEY]) |=> prdata[15:0] == $past(st_q.key))
        else $error("key read back wrong");

    a_locked_ignore: assert property (!unlocked
        |=> $stable({st_q.debug_run, st_q.clk_div, st_q.clk_src, st_q.running}))
        else $error("protected bits changed while locked");

    a_debug_freeze: assert property ((cpu_debug && !st_q.debug_run && !counter_clear)
        |=> $stable(st_q.count))
        else $error("counter moved in debug without debug run");

    a_debug_runs: assert property ((cpu_debug && st_q.debug_run && st_q.running
        && div_tick && !counter_clear) |=> st_q.count != $past(st_q.count))
        else $error("counter froze in debug with debug run");

    a_clear_zero: assert property ((counter_clear && !overflow)
        |=> st_q.count == 10'h000 && !sys_reset_req)
        else $error("clear did not zero the counter");

    a_clear_div: assert property (counter_clear |=> !div_tick)
        else $error("divider ticked right after clear");

    a_run_write: assert property ((wr_commit && hit[HIT_CTL] && unlocked)
        |=> st_q.running == ($past(apb_req.pwdata[3:0]) != 4'hA))
        else $error("run field write not applied");

    a_stopped_still: assert property ((!st_q.running && !counter_clear) |=> $stable(st_q.count))
        else $error("counter moved while stopped");

    a_run_readback: assert property ((rd_arm && hit[HIT_CTL])
        |=> pready && prdata[3:0] == ($past(st_q.running) ? 4'h0 : 4'hA))
        else $error("run field read back wrong");

    a_clear_reads0: assert property ((pready && $past(hit[HIT_CTL])) |-> !prdata[4])
        else $error("clear bit read as one");

    a_ctl_upper_zero: assert property ((rd_arm && hit[HIT_CTL]) |=> prdata[31:4] == 28'h000_0000)
        else $error("control read shows bits above run field");

    a_ready_answer: assert property ((apb_req.psel && apb_req.penable && !pready) |=> pready)
        else $error("access phase not answered next cycle");

    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");

    a_err_unmapped: assert property ((apb_req.psel && apb_req.penable && !pready && hit == 4'h0)
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("read data or error outside answer cycle");

endmodule : wdrt_top
`default_nettype wire

// *** bench/wdrt_clk_model.sv ***
// Clock generator model driving the source pins in bursts
`timescale 1ns/100ps
`default_nettype none
module wdrt_clk_model (
    input wire logic pclk,
    input wire logic go,
    input wire logic [1:0] src,
    input wire logic [15:0] len,
    output logic [3:0] osc_clk_in,
    output logic busy
);
    logic [15:0] left_q;
    logic [1:0] ph_q;
    initial begin
        osc_clk_in = 4'h0;
        busy = 1'b0;
        left_q = 16'h0;
        ph_q = 2'h0;
    end
    // Period of 4 pclk, idle sources stand still low
    always @(posedge pclk) begin
        if (!busy && go) begin
            busy <= 1'b1;
            left_q <= len;
            ph_q <= 2'h0;
        end else if (busy) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
                osc_clk_in[src] <= 1'b1;
            end
            if (ph_q == 2'h2) begin
                osc_clk_in <= 4'h0;
                left_q <= left_q - 16'h1;
                if (left_q == 16'h1) begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule : wdrt_clk_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the watchdog reset timer
`timescale 1ns/100ps
`default_nettype none
`include "wdrt_regs.svh"
module tb_top;
    import wdrt_pkg::*;
    typedef struct {
        string name;
        logic [32:0] exp;
        logic [32:0] mask;
    } wdrt_tb_exp_t;
    logic pclk;
    logic presetn;
    wdrt_apb_req_t req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] osc_clk_in;
    logic cpu_debug;
    logic sys_reset_req;
    logic go;
    logic [1:0] src;
    logic [15:0] len;
    logic busy;
    wdrt_tb_exp_t exp_q[$];
    wdrt_tb_exp_t e;
    int err_total;
    int compares;
    int cyc;
    logic [31:0] rnd;
    logic [3:0] run;
    logic [15:0] relock;
    logic [1:0] t_src[5] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h3};
    logic [1:0] t_div[5] = '{2'h0, 2'h3, 2'h0, 2'h3, 2'h2};
    logic [15:0] t_len[5] = '{16'h0100, 16'h0080, 16'h2000, 16'h0258, 16'h0009};
    logic [9:0] t_cnt[5] = '{10'h002, 10'h001, 10'h001, 10'h000, 10'h009};

    wdrt_top u_wdrt_top (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .osc_clk_in(osc_clk_in),
        .cpu_debug(cpu_debug),
        .sys_reset_req(sys_reset_req)
    );
    wdrt_clk_model u_wdrt_clk_model (
        .pclk(pclk),
        .go(go),
        .src(src),
        .len(len),
        .osc_clk_in(osc_clk_in),
        .busy(busy)
    );

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, input string name,
              input logic [32:0] exp, input logic [32:0] mask);
        wdrt_tb_exp_t n;
        n.name = name;
        n.exp = exp;
        n.mask = mask;
        @(posedge pclk);
        exp_q.push_back(n);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= wdata;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : xfer

    task wr(input logic [11:0] addr, input logic [31:0] d);
        xfer(1'b1, addr, d, "write_resp", 33'h0, 33'h1_0000_0000);
    endtask : wr

    task rd(input logic [11:0] addr, input string name, input logic [31:0] exp, input logic [31:0] mask);
        xfer(1'b0, addr, 32'h0, name, {1'b0, exp}, {1'b1, mask});
    endtask : rd

    task chk(input string name, input logic exp);
        @(posedge pclk);
        compares++;
        if (sys_reset_req !== exp) begin
            err_total++;
            $display("BAD %s expected %b seen %b", name, exp, sys_reset_req);
        end
    endtask : chk

    task burst(input logic [1:0] s, input logic [15:0] n);
        @(posedge pclk);
        src <= s;
        len <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
        repeat (8) @(posedge pclk);
    endtask : burst

    task note(input string name);
        $display("test %s finished", name);
    endtask : note

    ////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("BAD answer expected none seen %h", prdata);
            end else begin
                e = exp_q.pop_front();
                compares++;
                if (({pslverr, prdata} & e.mask) !== e.exp) begin
                    err_total++;
                    $display("BAD %s expected %h seen %h", e.name, e.exp, {pslverr, prdata} & e.mask);
                end
            end
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            $display("BAD timeout expected finish seen hang");
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////
    initial begin
        req = '0;
        presetn = 1'b0;
        cpu_debug = 1'b0;
        go = 1'b0;
        src = 2'h0;
        len = 16'h0;
        err_total = 0;
        compares = 0;
        cyc = 0;
        rnd = $urandom(32'h6D3D);
        rnd = $urandom();
        run = (rnd[19:16] == 4'hA) ? 4'h5 : rnd[19:16];
        relock = (rnd[15:0] == 16'h0096) ? 16'h1234 : rnd[15:0];
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`WDRT_OFF_CLK, "clk_ctrl", 32'h0, 32'hFFFF_FFFF);
        rd(`WDRT_OFF_CTL, "control", 32'h0000_000A, 32'hFFFF_FFFF);
        rd(`WDRT_OFF_KEY, "key", 32'h0, 32'hFFFF_FFFF);
        rd(`WDRT_OFF_STAT, "status", 32'h0, 32'hFFFF_FFFF);
        xfer(1'b0, {rnd[31:22], 2'h1}, 32'h0, "unmapped", 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        wr(`WDRT_OFF_CTL, {28'h0, run});
        wr(`WDRT_OFF_CLK, 32'h0000_0103);
        rd(`WDRT_OFF_CTL, "locked_ctl", 32'h0000_000A, 32'hFFFF_FFFF);
        rd(`WDRT_OFF_CLK, "locked_clk", 32'h0, 32'hFFFF_FFFF);
        note("reset_and_lock");
        wr(`WDRT_OFF_KEY, 32'h0000_0096);
        rd(`WDRT_OFF_STAT, "unlocked", 32'h0004_0000, 32'h0004_0000);
        wr(`WDRT_OFF_CLK, 32'h0000_0003);
        wr(`WDRT_OFF_CTL, {27'h0, 1'b1, run});
        wr(`WDRT_OFF_KEY, {16'h0, relock});
        rd(`WDRT_OFF_KEY, "key", {16'h0, relock}, 32'hFFFF_FFFF);
        rd(`WDRT_OFF_CTL, "running_ctl", 32'h0, 32'hFFFF_FFFF);
        rd(`WDRT_OFF_STAT, "started", 32'h0001_0000, 32'hFFFF_FFFF);
        burst(2'h3, 16'h0258);
        rd(`WDRT_OFF_STAT, "count_600", 32'h0001_0258, 32'hFFFF_FFFF);
        cpu_debug <= 1'b1;
        burst(2'h3, 16'h0032);
        rd(`WDRT_OFF_STAT, "frozen", 32'h0001_0258, 32'hFFFF_FFFF);
        cpu_debug <= 1'b0;
        note("start_and_freeze");
        wr(`WDRT_OFF_KEY, 32'h0000_0096);
        wr(`WDRT_OFF_CTL, {27'h0, 1'b1, run});
        wr(`WDRT_OFF_KEY, {16'h0, relock});
        rd(`WDRT_OFF_STAT, "cleared", 32'h0001_0000, 32'hFFFF_FFFF);
        burst(2'h3, 16'h03FF);
        chk("reset_early", 1'b0);
        rd(`WDRT_OFF_STAT, "count_max", 32'h0001_03FF, 32'hFFFF_FFFF);
        burst(2'h3, 16'h0001);
        chk("reset_req", 1'b1);
        rd(`WDRT_OFF_STAT, "wrapped", 32'h0003_0000, 32'hFFFF_FFFF);
        note("overflow");
        wr(`WDRT_OFF_KEY, 32'h0000_0096);
        wr(`WDRT_OFF_CTL, 32'h0000_000A);
        chk("sticky_req", 1'b1);
        burst(2'h3, 16'h0014);
        rd(`WDRT_OFF_STAT, "stopped", 32'h0006_0000, 32'hFFFF_FFFF);
        wr(`WDRT_OFF_CTL, 32'h0000_001A);
        chk("req_cleared", 1'b0);
        rd(`WDRT_OFF_CTL, "idle_ctl", 32'h0000_000A, 32'hFFFF_FFFF);
        note("stop_and_clear");
        wr(`WDRT_OFF_CLK, 32'h0000_0103);
        wr(`WDRT_OFF_CTL, {27'h0, 1'b1, run});
        cpu_debug <= 1'b1;
        burst(2'h3, 16'h0028);
        rd(`WDRT_OFF_STAT, "debug_run", 32'h0005_0028, 32'hFFFF_FFFF);
        cpu_debug <= 1'b0;
        note("debug_run");
        for (int i = 0; i < 5; i++) begin
            wr(`WDRT_OFF_CLK, {26'h0, t_div[i], 2'h0, t_src[i]});
            wr(`WDRT_OFF_CTL, {27'h0, 1'b1, run});
            burst(t_src[i], t_len[i]);
            rd(`WDRT_OFF_STAT, "ratio", {22'h0000140, t_cnt[i]}, 32'hFFFF_FFFF);
        end
        note("dividers");
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
